// [logic/pbsram_pkg.sv]
// constants and types for the pipelined burst sram port
`default_nettype none
package pbsram_pkg;
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned LANES     = 4;
  localparam int unsigned LANE_W    = 8;
  localparam int unsigned DATA_W    = LANES * LANE_W;
  localparam int unsigned DEPTH     = 1 << ADDR_W;
  localparam int unsigned BURST_W   = 2;
  localparam logic [1:0]  BURST_ONE = 2'h1;
  localparam logic [1:0]  BURST_ZRO = 2'h0;

  typedef enum logic [1:0] {
    PBSRAM_IDLE  = 2'b00,
    PBSRAM_READ  = 2'b01,
    PBSRAM_WRPND = 2'b11
  } pbsram_state_e;
endpackage : pbsram_pkg
`default_nettype wire

// [logic/pbsram_port.sv]
// pipelined burst sram port: registered controls, burst counter, array, data pins
`default_nettype none
module pbsram_port
  import pbsram_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic                select_low_first_n_i,
  input  wire logic                select_high_second_i,
  input  wire logic                select_low_third_n_i,
  input  wire logic                proc_addr_strobe_n_i,
  input  wire logic                ctrl_addr_strobe_n_i,
  input  wire logic                burst_advance_n_i,
  input  wire logic                all_bytes_write_n_i,
  input  wire logic                byte_write_enable_n_i,
  input  wire logic [LANES-1:0]    byte_lane_select_n_i,
  input  wire logic                out_enable_n_i,
  input  wire logic                sleep_request_i,
  input  wire logic                burst_order_i,
  input  wire logic [DATA_W-1:0]   data_in_i,
  input  wire logic [LANES-1:0]    parity_io_in_i,
  output logic      [DATA_W-1:0]   data_out_o,
  output logic      [LANES-1:0]    parity_io_out_o,
  output logic      [DATA_W-1:0]   data_oe_o,
  output logic      [LANES-1:0]    parity_io_oe_o
);

  // pin sampling stage: inputs are registered on the rising edge
  logic [ADDR_W-1:0] addr_q;
  logic              ce1n_q, ce2_q, ce3n_q, proc_addr_strobe_n_n_q, ctrl_addr_strobe_n_n_q, adv_n_q;
  logic              gw_n_q, bwe_n_q;
  logic [LANES-1:0]  bw_n_q, par_in_q;
  logic [DATA_W-1:0] din_q;
  // async controls: two flops before any logic reads them
  logic [1:0]        oe_n_sync_q, sleep_sync_q;
  logic              mode_q;

  always_ff @(posedge clk_i) begin
    addr_q   <= addr_i;
    ce1n_q   <= select_low_first_n_i;
    ce2_q    <= select_high_second_i;
    ce3n_q   <= select_low_third_n_i;
    proc_addr_strobe_n_n_q <= proc_addr_strobe_n_i;
    ctrl_addr_strobe_n_n_q <= ctrl_addr_strobe_n_i;
    adv_n_q  <= burst_advance_n_i;
    gw_n_q   <= all_bytes_write_n_i;
    bwe_n_q  <= byte_write_enable_n_i;
    bw_n_q   <= byte_lane_select_n_i;
    din_q    <= data_in_i;
    par_in_q <= parity_io_in_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      oe_n_sync_q  <= 2'b11;
      sleep_sync_q <= 2'b00;
    end else begin
      oe_n_sync_q  <= {oe_n_sync_q[0], out_enable_n_i};
      sleep_sync_q <= {sleep_sync_q[0], sleep_request_i};
    end
  end

  // strap held static by the host; re-sampled every cycle costs nothing
  always_ff @(posedge clk_i) begin
    mode_q <= burst_order_i;
  end

  wire oe_n_s  = oe_n_sync_q[1];
  wire sleep_s = sleep_sync_q[1];

  // address strobe decode
  wire selected = !ce1n_q && ce2_q && !ce3n_q;
  wire proc_addr_strobe_n_act = !proc_addr_strobe_n_n_q && !ce1n_q;
  wire ctrl_addr_strobe_n_act = proc_addr_strobe_n_n_q && !ctrl_addr_strobe_n_n_q;
  wire strobe   = (proc_addr_strobe_n_act || ctrl_addr_strobe_n_act) && !sleep_s;
  wire load     = strobe && selected;
  wire deselect = strobe && !selected;

  function automatic logic [LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                  input logic [LANES-1:0] bw_n);
    if (!gw_n) lane_mask = '1;
    else if (!bwe_n) lane_mask = ~bw_n;
    else lane_mask = '0;
  endfunction

  wire [LANES-1:0] wmask = lane_mask(gw_n_q, bwe_n_q, bw_n_q);

  pbsram_state_e state_q;
  logic [ADDR_W-1:0]  base_q;
  logic [BURST_W-1:0] start_q, cnt_q;
  logic               first_q;

  // burst address: linear add or interleaved xor, wraps in four
  function automatic logic [BURST_W-1:0] burst_lsb(input logic inter,
                                                   input logic [BURST_W-1:0] s,
                                                   input logic [BURST_W-1:0] c);
    burst_lsb = inter ? (s ^ c) : BURST_W'(s + c);
  endfunction

  wire [ADDR_W-1:0] cur_addr = {base_q[ADDR_W-1:BURST_W], burst_lsb(mode_q, start_q, cnt_q)};
  wire [ADDR_W-1:0] new_addr = addr_q;

  // controller write: single clock with write controls in the strobe cycle
  wire ctrl_addr_strobe_n_wr  = load && ctrl_addr_strobe_n_act && (wmask != '0);
  wire cont_act = (state_q != PBSRAM_IDLE) && !strobe && !sleep_s;
  wire cont_wr  = cont_act && (wmask != '0);
  wire advance  = cont_act && !adv_n_q;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= PBSRAM_IDLE;
      base_q  <= '0;
      start_q <= BURST_ZRO;
      cnt_q   <= BURST_ZRO;
      first_q <= 1'b0;
    end else begin
      if (load) begin
        base_q  <= new_addr;
        start_q <= new_addr[BURST_W-1:0];
        cnt_q   <= BURST_ZRO;
        first_q <= (state_q == PBSRAM_IDLE);
        state_q <= proc_addr_strobe_n_act ? PBSRAM_WRPND : PBSRAM_READ;
      end else begin
        first_q <= 1'b0;
        if (deselect) begin
          state_q <= PBSRAM_IDLE;
        end else if (cont_act) begin
          state_q <= PBSRAM_READ;
          if (advance) cnt_q <= BURST_W'(cnt_q + BURST_ONE);
        end
      end
    end
  end

  // storage array; sleep blocks access but keeps contents
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [LANES-1:0]  par_mem_q [DEPTH];
  logic [DATA_W-1:0] rd_q;
  logic [LANES-1:0]  rd_par_q;

  wire              do_wr   = ctrl_addr_strobe_n_wr || cont_wr;
  wire [ADDR_W-1:0] wr_addr = ctrl_addr_strobe_n_wr ? new_addr : cur_addr;

  always_ff @(posedge clk_i) begin
    if (do_wr && !sleep_s) begin
      for (int l = 0; l < LANES; l++) begin
        if (wmask[l]) begin
          mem_q[wr_addr][l*LANE_W +: LANE_W] <= din_q[l*LANE_W +: LANE_W];
          par_mem_q[wr_addr][l] <= par_in_q[l];
        end
      end
    end
  end

  // read address: new address on load, advanced burst address on advance, else current burst address
  wire [ADDR_W-1:0] rd_addr = load ? new_addr
                            : (advance ? {base_q[ADDR_W-1:BURST_W],
                               burst_lsb(mode_q, start_q, BURST_W'(cnt_q + BURST_ONE))}
                            : cur_addr);
  logic rd_valid_q;
  logic wr_seen_q;

  always_ff @(posedge clk_i) begin
    rd_q     <= mem_q[rd_addr];
    rd_par_q <= par_mem_q[rd_addr];
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_valid_q <= 1'b0;
      wr_seen_q  <= 1'b0;
    end else begin
      rd_valid_q <= (load || cont_act) && !sleep_s;
      wr_seen_q  <= do_wr;
    end
  end

  // output stage: drivers enabled from flops only
  wire drive = rd_valid_q && !oe_n_s && !first_q && !wr_seen_q && !do_wr && !sleep_s;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_out_o      <= '0;
      parity_io_out_o <= '0;
      data_oe_o       <= '0;
      parity_io_oe_o  <= '0;
    end else begin
      data_out_o      <= rd_q;
      parity_io_out_o <= rd_par_q;
      data_oe_o       <= {DATA_W{drive}};
      parity_io_oe_o  <= {LANES{drive}};
    end
  end

  first_read_hiz_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    first_q |=> (data_oe_o == '0)) else $error("first read cycle drove pins");
  write_hiz_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    do_wr |=> (data_oe_o == '0)) else $error("pins driven during write");
  oe_high_hiz_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    oe_n_s |=> (parity_io_oe_o == '0)) else $error("pins driven with oe high");
  proc_priority_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (load && !proc_addr_strobe_n_n_q) |=> (state_q == PBSRAM_WRPND)) else $error("proc strobe lost");
  ce1_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce1n_q && !proc_addr_strobe_n_n_q && ctrl_addr_strobe_n_n_q) |=> (state_q != PBSRAM_WRPND))
    else $error("proc strobe taken with ce1 high");
  counter_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    load |=> (start_q == $past(addr_q[BURST_W-1:0]) && cnt_q == BURST_ZRO))
    else $error("burst counter not loaded");
  sequence adv_seq;
    cont_act && !adv_n_q && !do_wr;
  endsequence
  advance_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    adv_seq |=> (cnt_q == BURST_W'($past(cnt_q) + BURST_ONE)))
    else $error("burst counter did not advance");
  select_need_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    load |-> (!ce1n_q && ce2_q && !ce3n_q)) else $error("load while unselected");
  gw_all_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !gw_n_q |-> (wmask == '1)) else $error("global write not all lanes");
  proc_wr_two_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (load && proc_addr_strobe_n_act) |-> !do_wr) else $error("proc write in first clock");
  // a processor write lands in the clock after its strobe
  sequence proc_load_seq;
    load && proc_addr_strobe_n_act;
  endsequence
  sequence data_cycle_seq;
    cont_act && (wmask != '0);
  endsequence
  proc_wr_second_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    proc_load_seq ##1 data_cycle_seq |-> do_wr)
    else $error("proc write second clock lost");
  ctrl_wr_one_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (load && ctrl_addr_strobe_n_act && (wmask != '0)) |-> do_wr)
    else $error("ctrl write not in one clock");
  byte_none_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (gw_n_q && bwe_n_q) |-> (wmask == '0)) else $error("lanes written without enable");
  adv_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cont_act && adv_n_q) |=> $stable(cnt_q)) else $error("burst moved without advance");
  deselect_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    deselect |=> (state_q == PBSRAM_IDLE)) else $error("deselect not idle");
  oe_pair_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ((data_oe_o == '0) == (parity_io_oe_o == '0))) else $error("data and parity oe split");
  read_data_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    drive |=> (data_out_o == $past(rd_q))) else $error("read data not registered");
  // sleep keeps the array but must stop pins and accesses
  sleep_hiz_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sleep_s |=> (data_oe_o == '0)) else $error("pins driven in sleep");
  sleep_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sleep_s |-> (!load && !do_wr)) else $error("access during sleep");

endmodule : pbsram_port
`default_nettype wire

// [testbench/pbsram_host.sv]
// partner model: controller driving the sram port pins
`default_nettype none
module pbsram_host
  import pbsram_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [35:0]       q_i,
  input  wire logic [35:0]       qoe_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [2:0]        sel_o,
  output logic      [4:0]        ctl_o,
  output logic      [3:0]        ln_o,
  output logic      [35:0]       pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] hd;
  // released lines show the write data in write cycles, else the inverted last value so stale data never looks valid
  assign pin_o = (qoe_i & q_i) | (~qoe_i & hd);
  initial begin
    addr_o = '0;
    sel_o = 3'h6;
    ctl_o = 5'h1F;
    ln_o = 4'hF;
    hd = '0;
  end
  // ctl is {proc strobe, ctrl strobe, advance, all-bytes write, byte write enable}
  task automatic cyc(input logic [4:0] c, input logic [2:0] s, input logic [ADDR_W-1:0] a,
                     input logic [3:0] l, input logic [35:0] d);
    @(negedge clk_i);
    ctl_o = c;
    sel_o = s;
    addr_o = a;
    ln_o = l;
    hd = (c[1] & c[0]) ? ~hd : d;
  endtask
endmodule // pbsram_host
`default_nettype wire

// [testbench/pbsram_port_tb_top.sv]
// self-checking bench for the pipelined burst sram port
`default_nettype none
module pbsram_port_tb_top
  import pbsram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int unsigned cy; logic [35:0] d; logic oe;} pbsram_note_s;
  logic              clk_i = 0;
  logic              rstn_i = 0;
  logic              oe_n = 0;
  logic              ord = 0;
  logic              zz = 0;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] base;
  logic [2:0]        sel;
  logic [4:0]        ctl;
  logic [3:0]        ln;
  logic [35:0]       pin, q, qoe;
  logic [35:0]       mem [DEPTH];
  pbsram_note_s      nq[$];
  pbsram_note_s      e;
  int unsigned       cnt = 0, fails = 0, n_tests = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) cnt <= cnt + 1;
  pbsram_port pbsram_port_i (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
    .select_low_first_n_i(sel[2]), .select_high_second_i(sel[1]),
    .select_low_third_n_i(sel[0]), .proc_addr_strobe_n_i(ctl[4]),
    .ctrl_addr_strobe_n_i(ctl[3]), .burst_advance_n_i(ctl[2]),
    .all_bytes_write_n_i(ctl[1]), .byte_write_enable_n_i(ctl[0]),
    .byte_lane_select_n_i(ln), .out_enable_n_i(oe_n), .sleep_request_i(zz),
    .burst_order_i(ord), .data_in_i(pin[31:0]), .parity_io_in_i(pin[35:32]),
    .data_out_o(q[31:0]), .parity_io_out_o(q[35:32]), .data_oe_o(qoe[31:0]),
    .parity_io_oe_o(qoe[35:32]));
  pbsram_host host_i (.clk_i(clk_i), .q_i(q), .qoe_i(qoe), .addr_o(addr), .sel_o(sel),
    .ctl_o(ctl), .ln_o(ln), .pin_o(pin));
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] c, input logic [ADDR_W-1:0] a, input logic [3:0] l,
                    input logic [35:0] d);
    host_i.cyc(c, 3'h2, a, l, d);
    for (int k = 0; k < LANES; k++)
      if (!c[1] || (!c[0] && !l[k])) begin
        mem[a][8*k +: 8] = d[8*k +: 8];
        mem[a][32+k] = d[32+k];
      end
  endtask
  // p is what the pins show, a is where the data should come from
  task automatic rd(input logic [4:0] c, input logic [2:0] s, input logic [ADDR_W-1:0] p,
                    input logic [ADDR_W-1:0] a, input logic oe);
    host_i.cyc(c, s, p, 4'hF, '0);
    nq.push_back('{cnt + 3, mem[a], oe});
  endtask
  always @(negedge clk_i)
    if (nq.size() != 0 && nq[0].cy == cnt) begin
      e = nq.pop_front();
      cmp(qoe, {36{e.oe}});
      if (e.oe)
        cmp(q, e.d);
    end
  task automatic give_verdict();
    fails += nq.size();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(4 * 2000);
    fails++;
    give_verdict();
  end
  initial begin
    logic [1:0] s;
    void'($urandom(38517));
    ord = 1'($urandom);
    base = ADDR_W'($urandom) & ~ADDR_W'(3);
    repeat (5) @(negedge clk_i);
    rstn_i = 1;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < 4; i++)
      wr(5'h15, base + ADDR_W'(i), 4'hF, 36'({$urandom, $urandom}));
    $display("test controller writes done");
    host_i.cyc(5'h0C, 3'h2, base + ADDR_W'(1), 4'h0, '0);
    wr(5'h1E, base + ADDR_W'(1), 4'($urandom), 36'({$urandom, $urandom}));
    host_i.cyc(5'h0C, 3'h2, base + ADDR_W'(2), 4'h0, '0);
    wr(5'h1F, base + ADDR_W'(2), 4'h0, '0);
    $display("test processor writes done");
    host_i.cyc(5'h04, 3'h2, base + ADDR_W'(3), 4'h0, 36'({$urandom, $urandom}));
    host_i.cyc(5'h1F, 3'h2, base, 4'hF, '0);
    $display("test strobe priority done");
    host_i.cyc(5'h0F, 3'h6, base, 4'hF, '0);
    host_i.cyc(5'h17, 3'h6, base, 4'hF, '0);
    s = 2'($urandom);
    rd(5'h17, 3'h2, base + ADDR_W'(s), base + ADDR_W'(s), 1'b0);
    for (int i = 1; i < 4; i++)
      rd(5'h1B, 3'($urandom), ADDR_W'($urandom),
         {base[ADDR_W-1:2], 2'(ord ? s ^ i : s + i)}, 1'b1);
    $display("test burst read done");
    repeat (5) @(negedge clk_i);
    oe_n = 1;
    repeat (3) @(negedge clk_i);
    rd(5'h17, 3'h2, base, base, 1'b0);
    repeat (5) @(negedge clk_i);
    oe_n = 0;
    repeat (3) @(negedge clk_i);
    $display("test output enable done");
    for (int i = 0; i < 8; i++) begin
      s = 2'($urandom);
      rd((i % 2) ? 5'h17 : 5'h0F, 3'h2, base + ADDR_W'(s), base + ADDR_W'(s), 1'b1);
    end
    repeat (8) @(negedge clk_i);
    $display("test back to back reads done");
    zz = 1;
    repeat (3) @(negedge clk_i);
    host_i.cyc(5'h15, 3'h2, base, 4'hF, 36'({$urandom, $urandom}));
    host_i.cyc(5'h1F, 3'h2, base, 4'hF, '0);
    zz = 0;
    repeat (3) @(negedge clk_i);
    rd(5'h17, 3'h2, base, base, 1'b1);
    repeat (5) @(negedge clk_i);
    $display("test sleep done");
    give_verdict();
  end
endmodule // pbsram_port_tb_top
`default_nettype wire
